// ### pkg/acx_map.vh
// Purpose: constants for the ac bridge excitation drive
// Assumes: core clock of 25 MHz (40 ns period)
// Notes:   idle levels are the output values while ac excitation is off
`ifndef ACX_MAP_VH
`define ACX_MAP_VH

// core clock period in ns
`define ACX_CLK_PERIOD_NS    40
// non-overlap gap, in master clock periods (the core clock is the master clock)
`define ACX_GAP_MCLK_PERIODS 1
// cycles of the non-overlap gap, derived from the count of periods
`define ACX_GAP_CYCLES       (`ACX_GAP_MCLK_PERIODS * 1)
// default length of one excitation phase, in core clock cycles
`define ACX_HALF_CYCLES      1024
// width of the phase length counter
`define ACX_HALF_CNT_W       16
// width of the gap counter
`define ACX_GAP_CNT_W        4

// output levels held while ac excitation is disabled and during reset
`define ACX_IDLE_PHASE_A     1'b1
`define ACX_IDLE_PHASE_A_N   1'b0
`define ACX_IDLE_PHASE_B     1'b0
`define ACX_IDLE_PHASE_B_N   1'b1

// state encodings of the excitation sequencer
`define ACX_ST_IDLE          3'h0
`define ACX_ST_NORM          3'h1
`define ACX_ST_GAP_TO_REV    3'h2
`define ACX_ST_REV           3'h3
`define ACX_ST_GAP_TO_NORM   3'h4

`endif

// ### logic/acx_rate_div.v
// Purpose: phase length timer for the excitation sequencer
// Assumes: restart_in is high in the cycle before the first cycle of a phase
// Notes:   tick_out is high in the last cycle of a phase of HALF_CYCLES cycles
`timescale 1ns/1ps
`default_nettype none
`include "acx_map.vh"

module acx_rate_div #(
  parameter integer HALF_CYCLES = `ACX_HALF_CYCLES,
  parameter integer CNT_W       = `ACX_HALF_CNT_W
) (
  input  wire             core_clk_in,
  input  wire             reset_in,
  input  wire             restart_in,
  output wire             tick_out
);

  localparam integer     LAST_I = HALF_CYCLES - 1;
  localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

  reg  [CNT_W-1:0] cnt_reg;
  reg  [CNT_W-1:0] cnt_next;

  always @* begin
    if (restart_in || cnt_reg == LAST) begin
      cnt_next = {CNT_W{1'b0}};
    end else begin
      cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // a restart in the same cycle hides a stale end of count
  assign tick_out = (cnt_reg == LAST) && !restart_in;

endmodule // acx_rate_div

`default_nettype wire

// ### logic/acx_drive.v
// Purpose: drive of the four bridge excitation reversing outputs
// Assumes: ac_excite_enable_in is synchronous to core_clk_in
// Notes:   all outputs are flip-flops loaded from one decoded state,
//          so the complements never disagree with their phases;
//          a disable in reversed polarity still passes through a gap;
//          the gap counter is sized for gaps of up to 16 periods
`timescale 1ns/1ps
`default_nettype none
`include "acx_map.vh"

// Overview of operation
// - phase b toggles opposite phase a
// - phase b held low when disabled
// - one-period gap, phases never both high
// - phase b complement, high when disabled
// - phase a high normal, low reversed
// - phase a held high when disabled
// - phase a complement, low means normal
// - phase a complement low when disabled
module acx_drive #(
  parameter integer HALF_CYCLES = `ACX_HALF_CYCLES,
  parameter integer GAP_CYCLES  = `ACX_GAP_CYCLES
) (
  input  wire core_clk_in,
  input  wire reset_in,
  input  wire ac_excite_enable_in,
  output reg  excite_phase_a_out,
  output reg  excite_phase_a_n_out,
  output reg  excite_phase_b_out,
  output reg  excite_phase_b_n_out,
  output reg  excite_reversed_out,
  output reg  excite_switch_out,
  output reg  excite_active_out
);

  localparam [2:0] ST_IDLE        = `ACX_ST_IDLE;
  localparam [2:0] ST_NORM        = `ACX_ST_NORM;
  localparam [2:0] ST_GAP_TO_REV  = `ACX_ST_GAP_TO_REV;
  localparam [2:0] ST_REV         = `ACX_ST_REV;
  localparam [2:0] ST_GAP_TO_NORM = `ACX_ST_GAP_TO_NORM;

  localparam integer         GAP_W    = `ACX_GAP_CNT_W;
  localparam integer         GAP_LAST = GAP_CYCLES - 1;
  // a gap longer than the counter holds would wrap, so keep GAP_W in step
  localparam [GAP_W-1:0]     GAP_LOAD = GAP_LAST[GAP_W-1:0];

  // decode of a state into {phase a, phase b}
  function [1:0] acx_levels;
    input [2:0] st;
    begin
      case (st)
        ST_IDLE:        acx_levels = {`ACX_IDLE_PHASE_A, `ACX_IDLE_PHASE_B};
        ST_NORM:        acx_levels = 2'h2;
        ST_GAP_TO_REV:  acx_levels = 2'h0;
        ST_REV:         acx_levels = 2'h1;
        ST_GAP_TO_NORM: acx_levels = 2'h0;
        default:        acx_levels = {`ACX_IDLE_PHASE_A, `ACX_IDLE_PHASE_B};
      endcase
    end
  endfunction

  // true for the two states in which one phase is driving the bridge
  function acx_is_phase;
    input [2:0] st;
    begin
      acx_is_phase = (st == ST_NORM) || (st == ST_REV);
    end
  endfunction

  // one step down of the gap counter, shared by both gap states
  function [GAP_W-1:0] acx_gap_step;
    input [GAP_W-1:0] cnt;
    begin
      acx_gap_step = cnt - {{(GAP_W-1){1'b0}}, 1'b1};
    end
  endfunction

  reg  [2:0]       state_reg;
  reg  [2:0]       state_next;
  reg  [GAP_W-1:0] gap_cnt_reg;
  reg  [GAP_W-1:0] gap_cnt_next;
  reg              restart_div;
  wire             phase_tick;
  wire             gap_done;
  wire [1:0]       levels_next;
  // next values of the registered outputs
  reg              phase_a_next;
  reg              phase_b_next;
  reg              reversed_next;
  reg              switch_next;
  reg              active_next;

  assign gap_done = (gap_cnt_reg == {GAP_W{1'b0}});

  acx_rate_div #(
    .HALF_CYCLES (HALF_CYCLES),
    .CNT_W       (`ACX_HALF_CNT_W)
  ) u_rate_div (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .restart_in  (restart_div),
    .tick_out    (phase_tick)
  );

  // sequencer: a phase never ends without passing through a gap,
  // except when excitation is switched off in norm, which goes straight to idle
  always @* begin
    state_next   = state_reg;
    gap_cnt_next = gap_cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ac_excite_enable_in) begin
          state_next = ST_NORM;
        end
      end
      ST_NORM: begin
        if (!ac_excite_enable_in) begin
          // phase a already at its idle level, no gap needed
          state_next = ST_IDLE;
        end else if (phase_tick) begin
          state_next   = ST_GAP_TO_REV;
          gap_cnt_next = GAP_LOAD;
        end
      end
      ST_GAP_TO_REV: begin
        if (gap_done) begin
          state_next = ac_excite_enable_in ? ST_REV : ST_IDLE;
        end else begin
          gap_cnt_next = acx_gap_step(gap_cnt_reg);
        end
      end
      ST_REV: begin
        // leaving reversed polarity always goes through a gap first
        if (!ac_excite_enable_in || phase_tick) begin
          state_next   = ST_GAP_TO_NORM;
          gap_cnt_next = GAP_LOAD;
        end
      end
      ST_GAP_TO_NORM: begin
        if (gap_done) begin
          state_next = ac_excite_enable_in ? ST_NORM : ST_IDLE;
        end else begin
          gap_cnt_next = acx_gap_step(gap_cnt_reg);
        end
      end
      default: begin
        state_next   = ST_IDLE;
        gap_cnt_next = {GAP_W{1'b0}};
      end
    endcase
  end

  // the phase timer starts afresh on every entry into a driving state
  always @* begin
    restart_div = acx_is_phase(state_next) && (state_next != state_reg);
  end

  assign levels_next = acx_levels(state_next);

  // last guard: a decode fault must never close both switch pairs at once
  always @* begin
    phase_a_next  = levels_next[1];
    phase_b_next  = levels_next[0];
    if (levels_next[1] && levels_next[0]) begin
      phase_a_next = 1'b0;
      phase_b_next = 1'b0;
    end
    reversed_next = (state_next == ST_REV);
    switch_next   = restart_div;
    active_next   = (state_next != ST_IDLE);
  end

  // sequencer state and gap counter
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      state_reg   <= ST_IDLE;
      gap_cnt_reg <= {GAP_W{1'b0}};
    end else begin
      state_reg   <= state_next;
      gap_cnt_reg <= gap_cnt_next;
    end
  end

  // outputs loaded from the next state so they land together with it;
  // each complement comes from its own flop, never from a gate on a phase
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      excite_phase_a_out   <= `ACX_IDLE_PHASE_A;
      excite_phase_a_n_out <= `ACX_IDLE_PHASE_A_N;
    end else begin
      excite_phase_a_out   <= phase_a_next;
      excite_phase_a_n_out <= ~phase_a_next;
    end
  end

  // phase b pair, reversed drive of the bridge
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      excite_phase_b_out   <= `ACX_IDLE_PHASE_B;
      excite_phase_b_n_out <= `ACX_IDLE_PHASE_B_N;
    end else begin
      excite_phase_b_out   <= phase_b_next;
      excite_phase_b_n_out <= ~phase_b_next;
    end
  end

  // status for the converter: polarity, a pulse when a phase begins,
  // and whether the sequencer is away from its idle state
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      excite_reversed_out <= 1'b0;
      excite_switch_out   <= 1'b0;
      excite_active_out   <= 1'b0;
    end else begin
      excite_reversed_out <= reversed_next;
      excite_switch_out   <= switch_next;
      excite_active_out   <= active_next;
    end
  end

endmodule // acx_drive

`default_nettype wire

// ### tb/acx_bridge_model.sv
// Purpose: model of the external bridge reversing switches
// Assumes: each phase output closes one switch pair while high and its complement is low
// Notes: 3 on polarity_out means a shorted bridge
`timescale 1ns/1ps
`default_nettype none
module acx_bridge_model (
  input  wire logic       a_in,
  input  wire logic       a_n_in,
  input  wire logic       b_in,
  input  wire logic       b_n_in,
  output logic      [1:0] polarity_out
);
  // 1 normal, 2 reversed, 0 open
  always_comb polarity_out = {b_in & ~b_n_in, a_in & ~a_n_in};
endmodule // acx_bridge_model
`default_nettype wire

// ### tb/acx_drive_props.sv
// Purpose: assertions on the excitation outputs
// Assumes: HALF_CYCLES 4, GAP_CYCLES 1
// Notes: bound to acx_drive
`timescale 1ns/1ps
`default_nettype none
module acx_drive_props (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ac_excite_enable_in,
  input wire logic excite_phase_a_out,
  input wire logic excite_phase_a_n_out,
  input wire logic excite_phase_b_out,
  input wire logic excite_phase_b_n_out,
  input wire logic excite_reversed_out
);
  wire en = ac_excite_enable_in;
  wire a  = excite_phase_a_out;
  wire b  = excite_phase_b_out;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  no_overlap_a: assert property (!(a && b)) else $error("both phases high");
  a_inverse_a: assert property (excite_phase_a_n_out == !a) else $error("a inverse");
  b_inverse_a: assert property (excite_phase_b_n_out == !b) else $error("b inverse");
  idle_hold_a: assert property (!en [*6] |=> a && !b) else $error("idle levels");
  gap_rev_a: assert property ($rose(b) |-> !$past(a)) else $error("no gap before b");
  gap_norm_a: assert property ($rose(a) |-> !$past(b)) else $error("no gap before a");
  rev_len_a: assert property (en [*6] ##0 $fell(b) |-> $past(b, 4) && !$past(b, 5))
    else $error("phase b length");
  anti_phase_a: assert property (en [*3] ##0 $fell(a) ##1 en |-> $rose(b))
    else $error("b not after gap");
  polarity_flag_a: assert property (excite_reversed_out == b) else $error("polarity flag");
endmodule // acx_drive_props
bind acx_drive acx_drive_props u_props (
  .core_clk_in          (core_clk_in),
  .reset_in             (reset_in),
  .ac_excite_enable_in  (ac_excite_enable_in),
  .excite_phase_a_out   (excite_phase_a_out),
  .excite_phase_a_n_out (excite_phase_a_n_out),
  .excite_phase_b_out   (excite_phase_b_out),
  .excite_phase_b_n_out (excite_phase_b_n_out),
  .excite_reversed_out  (excite_reversed_out)
);
`default_nettype wire

// ### tb/acx_drive_bench.sv
// Purpose: self-checking bench of the excitation drive
// Assumes: short phases of 4 cycles, gap of 1
// Notes: outputs sampled on the falling edge
`timescale 1ns/1ps
`default_nettype none
module acx_drive_bench;
  logic       clk = 0;
  logic       rst = 1;
  logic       en  = 0;
  wire        a, an, b, bn, rev, sw, act;
  wire  [1:0] pol;
  int         err_total = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  time        last_rise = 0;
  always #20 clk = ~clk;
  acx_drive #(.HALF_CYCLES(4), .GAP_CYCLES(1)) uut (.core_clk_in(clk), .reset_in(rst),
    .ac_excite_enable_in(en), .excite_phase_a_out(a), .excite_phase_a_n_out(an),
    .excite_phase_b_out(b), .excite_phase_b_n_out(bn), .excite_reversed_out(rev),
    .excite_switch_out(sw), .excite_active_out(act));
  acx_bridge_model u_sw (.a_in(a), .a_n_in(an), .b_in(b), .b_n_in(bn), .polarity_out(pol));
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // a whole norm, gap, reversed, gap sequence twice
  task t_walk;
    int i;
    logic ea, eb, es;
    logic [8:0] ex;
    @(posedge clk) en <= 1;
    for (i = 0; i < 8 && sw !== 1'b1; i++) @(negedge clk);
    for (i = 0; i < 20; i++) begin
      ea = (i % 10) < 4;
      eb = (i % 10) > 4 && (i % 10) < 9;
      es = (i % 10) == 0 || (i % 10) == 5;
      ex = {ea, ~ea, eb, ~eb, eb, ea, eb, es, 1'b1};
      chk({a, an, b, bn, pol, rev, sw, act} === ex, "walk step");
      @(negedge clk);
    end
  endtask
  // drop enable at the start of reversed or norm, or lead cycles later
  // so that the drop is first seen inside the gap that follows norm
  task t_disable(input logic in_rev, input int lead);
    int i;
    for (i = 0; i < 12 && (sw !== 1'b1 || b !== in_rev); i++) @(negedge clk);
    repeat (lead) @(negedge clk);
    @(posedge clk) en <= 0;
    @(negedge clk);
    if (lead > 0) begin
      chk({a, an, b, bn, act} === 5'h0B, "gap kept after late disable");
    end
    @(negedge clk);
    if (in_rev) begin
      chk({a, an, b, bn, act} === 5'h0B, "gap before idle");
      @(negedge clk);
    end
    for (i = 0; i < 6; i++) begin
      chk({a, an, b, bn, act, sw} === 6'h24, "idle after disable");
      @(negedge clk);
    end
  endtask
  // every move of the four phase outputs must fall in the time step of a rising edge
  always @(posedge clk) last_rise = $time;
  always @(a or an or b or bn) begin
    if (!rst) begin
      chk($time == last_rise, "output moved off a clock edge");
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk({a, an, b, bn, act, sw} === 6'h24, "reset levels");
    t_walk();
    t_disable(1'b1, 0);
    @(posedge clk) en <= 1;
    t_disable(1'b0, 0);
    @(posedge clk) en <= 1;
    t_disable(1'b0, 3);
    report_and_stop();
  end
endmodule // acx_drive_bench
`default_nettype wire
